// ===== hdl/usart_top.sv
// Serial transceiver core: APB registers, receiver, sync detection,
// status and modem controls. Baud clocks and modem lines are sampled
// by CLK_I; 1X baud clocks, one bit per clock cycle of the line.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
// How it works
// - Stale character may show ready after re-enable
// - Reset clears the received character flag
// - External sync mode disables pattern matching
// - External sync status clears on status read
// - Asserted external sync keeps status high
// - Status snapshot follows events within bound
// - Transmit ready pin rises within eight
// - Receive ready pin rises within 24
// - Internal sync found within 24 clocks
// - Transmitter empty within twenty clocks unless a new character or sync fill starts
// - Command controls update within eight clocks
// - DSR and CTS reach status quickly
// - Data access drops its ready pin
// - Disabled receiver hides ready, keeps assembling
// - Status read clears sync found
module usart_top import usart_pkg::*; (
   input wire logic CLK_I,
   input wire logic RESET_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic TRANSMIT_BAUD_CLOCK_I,
   input wire logic RECEIVE_BAUD_CLOCK_I,
   input wire logic SERIAL_IN_I,
   input wire logic DSR_N_I,
   input wire logic CTS_N_I,
   input wire logic EXT_SYNC_I,
   output logic SERIAL_OUT_O,
   output logic DTR_N_O,
   output logic RTS_N_O,
   output logic TRANSMIT_READY_O,
   output logic RECEIVE_READY_O,
   output logic TRANSMITTER_EMPTY_O,
   output logic SYNC_FOUND_O
);
   logic txc_fall, rxc_rise, rxc_fall, rxd_lvl, dsr_n_lvl, cts_n_lvl, ext_lvl;
   logic setup, acc, hit, wr_data, wr_cmd, wr_mode, rd_data, rd_stat, irst, stat_sel;
   logic [7:0] cmd, next_cmd;
   logic [15:0] mode, next_mode;
   logic [7:0] tx_buf, next_tx_buf, rx_buf, next_rx_buf, rx_sh, next_rx_sh, shifted;
   logic buf_full, next_buf_full, rx_full, next_rx_full, ovr, next_ovr, frm, next_frm;
   logic sync_found, next_sync_found, hunt, next_hunt;
   rx_state_t rx_st, next_rx_st;
   logic [2:0] rx_cnt, next_rx_cnt;
   logic [STAT_W-1:0] st, next_st, live;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr, next_transmit_ready, next_receive_ready, next_dtr_n, next_rts_n;
   logic rx_done, int_hit, sync_mode, ext_mode;
   logic tx_take, tx_done, tx_busy, tx_txd;

   // ==========================================================
   // Input synchronisers
   edge_sync #(.INIT(1'b0)) u_txc (.clk_i(CLK_I), .reset_i(RESET_I),
      .async_i(TRANSMIT_BAUD_CLOCK_I), .level_o(), .rise_o(), .fall_o(txc_fall));
   edge_sync #(.INIT(1'b0)) u_rxc (.clk_i(CLK_I), .reset_i(RESET_I),
      .async_i(RECEIVE_BAUD_CLOCK_I), .level_o(), .rise_o(rxc_rise), .fall_o(rxc_fall));
   edge_sync #(.INIT(1'b1)) u_rxd (.clk_i(CLK_I), .reset_i(RESET_I),
      .async_i(SERIAL_IN_I), .level_o(rxd_lvl), .rise_o(), .fall_o());
   edge_sync #(.INIT(1'b1)) u_dsr (.clk_i(CLK_I), .reset_i(RESET_I),
      .async_i(DSR_N_I), .level_o(dsr_n_lvl), .rise_o(), .fall_o());
   edge_sync #(.INIT(1'b1)) u_cts (.clk_i(CLK_I), .reset_i(RESET_I),
      .async_i(CTS_N_I), .level_o(cts_n_lvl), .rise_o(), .fall_o());
   edge_sync #(.INIT(1'b0)) u_ext (.clk_i(CLK_I), .reset_i(RESET_I),
      .async_i(EXT_SYNC_I), .level_o(ext_lvl), .rise_o(), .fall_o());

   // ==========================================================
   // Transmitter
   serial_tx u_tx (
      .clk_i(CLK_I),
      .reset_i(RESET_I || irst),
      .tick_i(txc_fall),
      .go_i(cmd[CMD_TRANSMIT_ENABLE_CMD] && !cts_n_lvl),
      .full_i(buf_full),
      .data_i(tx_buf),
      .sync_mode_i(sync_mode),
      .sync_chr_i(mode[MODE_CHR +: 8]),
      .take_o(tx_take),
      .done_o(tx_done),
      .busy_o(tx_busy),
      .txd_o(tx_txd)
   );

   // ==========================================================
   // APB decode; zero wait states, answer registered in setup
   assign setup = PSEL_I && !PENABLE_I;
   assign acc = PSEL_I && PENABLE_I && PREADY_O;
   assign hit = (PADDR_I == ADDR_DATA) || (PADDR_I == ADDR_CMD) ||
      (PADDR_I == ADDR_MODE) || (PADDR_I == ADDR_STAT);
   assign wr_data = acc && PWRITE_I && (PADDR_I == ADDR_DATA);
   assign wr_cmd = acc && PWRITE_I && (PADDR_I == ADDR_CMD);
   assign wr_mode = acc && PWRITE_I && (PADDR_I == ADDR_MODE);
   assign rd_data = acc && !PWRITE_I && (PADDR_I == ADDR_DATA);
   assign rd_stat = acc && !PWRITE_I && (PADDR_I == ADDR_STAT);
   assign stat_sel = PSEL_I && !PWRITE_I && (PADDR_I == ADDR_STAT);
   assign irst = wr_cmd && PWDATA_I[CMD_IRST];
   assign sync_mode = mode[MODE_SYNC];
   assign ext_mode = mode[MODE_EXT];
   assign shifted = {rxd_lvl, rx_sh[7:1]};
   assign live = {!cts_n_lvl, !dsr_n_lvl, sync_found, frm, ovr, 1'b0,
      !tx_busy, rx_full, !buf_full};

   // ==========================================================
   // Next values
   always_comb begin
      next_cmd = cmd;
      next_mode = mode;
      next_tx_buf = tx_buf;
      next_buf_full = buf_full;
      next_rx_buf = rx_buf;
      next_rx_full = rx_full;
      next_ovr = ovr;
      next_frm = frm;
      next_hunt = hunt;
      next_rx_st = rx_st;
      next_rx_cnt = rx_cnt;
      next_rx_sh = rx_sh;
      rx_done = 1'b0;
      int_hit = 1'b0;
      if (wr_mode) begin
         next_mode = PWDATA_I[15:0];
      end
      if (wr_cmd) begin
         next_cmd = PWDATA_I[7:0];
         next_cmd[CMD_ERST] = 1'b0;
         next_cmd[CMD_IRST] = 1'b0;
         next_hunt = PWDATA_I[CMD_HUNT] && sync_mode;
         if (PWDATA_I[CMD_ERST]) begin
            next_ovr = 1'b0;
            next_frm = 1'b0;
         end
      end
      // Receiver keeps assembling whatever the enable bit says
      if (rxc_rise) begin
         unique case (rx_st)
            RX_IDLE: begin
               if (!sync_mode && !rxd_lvl) begin
                  next_rx_st = RX_DATA;
                  next_rx_cnt = 3'h0;
               end else if (sync_mode && hunt && !ext_mode) begin
                  next_rx_sh = shifted;
                  if (shifted == mode[MODE_CHR +: 8]) begin
                     int_hit = 1'b1;
                     next_hunt = 1'b0;
                     next_rx_cnt = 3'h0;
                     next_rx_st = RX_DATA;
                  end
               end
            end
            RX_DATA: begin
               next_rx_sh = shifted;
               next_rx_cnt = rx_cnt + 3'h1;
               if (rx_cnt == 3'h7) begin
                  if (sync_mode) begin
                     rx_done = 1'b1;
                  end else begin
                     next_rx_st = RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               rx_done = 1'b1;
               next_frm = next_frm || !rxd_lvl;
               next_rx_st = RX_IDLE;
            end
            default: begin
               next_rx_st = RX_IDLE;
            end
         endcase
      end
      // External sync ends the hunt only on the falling baud edge
      if (sync_mode && ext_mode && hunt && rxc_fall && ext_lvl) begin
         next_hunt = 1'b0;
         next_rx_cnt = 3'h0;
         next_rx_st = RX_DATA;
      end
      if (wr_cmd && PWDATA_I[CMD_HUNT] && sync_mode) begin
         next_rx_st = RX_IDLE;
      end
      if (rx_done) begin
         next_rx_buf = sync_mode ? shifted : rx_sh;
         next_ovr = next_ovr || rx_full;
      end
      // Re-enable leaves a stale character standing
      if (rd_data) begin
         next_rx_full = 1'b0;
      end
      if (rx_done) begin
         next_rx_full = 1'b1;
      end
      if (ext_mode) begin
         next_sync_found = ext_lvl || (sync_found && !rd_stat);
      end else begin
         next_sync_found = int_hit || (sync_found && !rd_stat);
      end
      if (tx_take) begin
         next_buf_full = 1'b0;
      end
      // Host write loads the buffer even when full, and wins over a take in the same cycle
      if (wr_data) begin
         next_tx_buf = PWDATA_I[7:0];
         next_buf_full = 1'b1;
      end
      if (irst) begin
         next_cmd = CMD_RESET;
         next_mode = MODE_RESET;
         next_buf_full = 1'b0;
         next_rx_full = 1'b0;
         next_ovr = 1'b0;
         next_frm = 1'b0;
         next_sync_found = 1'b0;
         next_hunt = 1'b0;
         next_rx_st = RX_IDLE;
      end
      // Snapshot frozen while software reads it, so bits stay coherent
      next_st = stat_sel ? st : live;
      next_transmit_ready = !next_buf_full && !cts_n_lvl && next_cmd[CMD_TRANSMIT_ENABLE_CMD];
      next_receive_ready = next_rx_full && next_cmd[CMD_RXE];
      next_dtr_n = !next_cmd[CMD_DTR];
      next_rts_n = !next_cmd[CMD_RTS];
      next_pready = setup;
      next_pslverr = setup && !hit;
      next_prdata = 32'h0000_0000;
      if (setup && !PWRITE_I) begin
         unique case (PADDR_I)
            ADDR_DATA: next_prdata = {24'h00_0000, rx_buf};
            ADDR_CMD: next_prdata = {24'h00_0000, cmd};
            ADDR_MODE: next_prdata = {16'h0000, mode};
            ADDR_STAT: next_prdata = {23'h00_0000, st};
            default: next_prdata = 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         cmd <= CMD_RESET;
         mode <= MODE_RESET;
         tx_buf <= 8'h00;
         buf_full <= 1'b0;
         rx_buf <= 8'h00;
         rx_full <= 1'b0;
         ovr <= 1'b0;
         frm <= 1'b0;
         sync_found <= 1'b0;
         hunt <= 1'b0;
         rx_st <= RX_IDLE;
         rx_cnt <= 3'h0;
         rx_sh <= 8'h00;
         st <= '0;
         PRDATA_O <= 32'h0000_0000;
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
         SERIAL_OUT_O <= 1'b1;
         DTR_N_O <= 1'b1;
         RTS_N_O <= 1'b1;
         TRANSMIT_READY_O <= 1'b0;
         RECEIVE_READY_O <= 1'b0;
         TRANSMITTER_EMPTY_O <= 1'b1;
         SYNC_FOUND_O <= 1'b0;
      end else begin
         cmd <= next_cmd;
         mode <= next_mode;
         tx_buf <= next_tx_buf;
         buf_full <= next_buf_full;
         rx_buf <= next_rx_buf;
         rx_full <= next_rx_full;
         ovr <= next_ovr;
         frm <= next_frm;
         sync_found <= next_sync_found;
         hunt <= next_hunt;
         rx_st <= next_rx_st;
         rx_cnt <= next_rx_cnt;
         rx_sh <= next_rx_sh;
         st <= next_st;
         PRDATA_O <= next_prdata;
         PREADY_O <= next_pready;
         PSLVERR_O <= next_pslverr;
         SERIAL_OUT_O <= tx_txd && !cmd[CMD_BRK];
         DTR_N_O <= next_dtr_n;
         RTS_N_O <= next_rts_n;
         TRANSMIT_READY_O <= next_transmit_ready;
         RECEIVE_READY_O <= next_receive_ready;
         TRANSMITTER_EMPTY_O <= !tx_busy;
         SYNC_FOUND_O <= next_sync_found;
      end
   end

   // ==========================================================
   // Assertions
   localparam int LAT_CLR = RDY_CLR_CYC;
   localparam int LAT_TRANSMIT_READY = TRANSMIT_READY_MAX_CYC;
   localparam int LAT_RECEIVE_READY = RECEIVE_READY_MAX_CYC;
   localparam int LAT_ISYNC = ISYNC_MAX_CYC;
   localparam int LAT_TXE = TXE_MAX_CYC;

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RESET_I);

   sequence s_data_rd;
      rd_data && !rx_done;
   endsequence
   sequence s_ext_release;
      ext_mode && rd_stat && !ext_lvl;
   endsequence
   sequence s_cts_on;
      $fell(cts_n_lvl) ##1 (!cts_n_lvl && !stat_sel) [*2];
   endsequence

   chk_transmit_ready_clear: assert property (wr_data |-> ##[1:LAT_CLR] !TRANSMIT_READY_O)
      else $error("transmit ready stayed high after data write");
   chk_receive_ready_clear: assert property (s_data_rd |-> ##[1:LAT_CLR] !RECEIVE_READY_O)
      else $error("receive ready stayed high after data read");
   chk_ext_hold: assert property (ext_mode && ext_lvl && !irst |=> SYNC_FOUND_O)
      else $error("sync found dropped while external sync held");
   chk_ext_clear: assert property (s_ext_release |=> !SYNC_FOUND_O)
      else $error("sync found not cleared by status read");
   chk_int_off: assert property (ext_mode && !ext_lvl && !SYNC_FOUND_O |=> !SYNC_FOUND_O)
      else $error("internal sync match acted in external mode");
   chk_isync_delay: assert property (int_hit && !irst |-> ##[1:LAT_ISYNC] SYNC_FOUND_O)
      else $error("internal sync found too late");
   chk_ctrl_delay: assert property (wr_cmd && !PWDATA_I[CMD_IRST] |=>
      (DTR_N_O != $past(PWDATA_I[CMD_DTR])) && (RTS_N_O != $past(PWDATA_I[CMD_RTS])))
      else $error("modem controls missed command write");
   chk_rx_gate: assert property (!cmd[CMD_RXE] && !wr_cmd |=> !RECEIVE_READY_O)
      else $error("receive ready shown while receiver disabled");
   chk_transmit_ready_set: assert property (tx_take && !wr_cmd && !wr_data
      |-> ##[1:LAT_TRANSMIT_READY] TRANSMIT_READY_O)
      else $error("transmit ready late after buffer emptied");
   chk_receive_ready_set: assert property (rx_done && cmd[CMD_RXE] && !wr_cmd
      |-> ##[1:LAT_RECEIVE_READY] RECEIVE_READY_O)
      else $error("receive ready late after character");
   chk_cts_status: assert property (s_cts_on |-> st[STAT_CTS])
      else $error("clear to send missing from status");
   chk_txe_delay: assert property (tx_done && !tx_take && !irst
      |-> ##[1:LAT_TXE] TRANSMITTER_EMPTY_O)
      else $error("transmitter empty late");
endmodule

// ===== hdl/usart_pkg.sv
// Shared constants, register map and state types of the serial transceiver.
// Assumes a 200 MHz system clock and an APB register port.
package usart_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0] ADDR_DATA = 8'h00;
   localparam logic [7:0] ADDR_CMD = 8'h04;
   localparam logic [7:0] ADDR_MODE = 8'h08;
   localparam logic [7:0] ADDR_STAT = 8'h0C;
   // ==========================================================
   // Command bits
   localparam int CMD_TRANSMIT_ENABLE_CMD = 0;
   localparam int CMD_DTR = 1;
   localparam int CMD_RXE = 2;
   localparam int CMD_BRK = 3;
   localparam int CMD_ERST = 4;
   localparam int CMD_RTS = 5;
   localparam int CMD_IRST = 6;
   localparam int CMD_HUNT = 7;
   // ==========================================================
   // Mode bits
   localparam int MODE_SYNC = 0;
   localparam int MODE_EXT = 1;
   localparam int MODE_CHR = 8;
   // ==========================================================
   // Status bits
   localparam int STAT_TXBUF = 0;
   localparam int STAT_RECEIVE_READY = 1;
   localparam int STAT_TXE = 2;
   localparam int STAT_OVR = 4;
   localparam int STAT_FRM = 5;
   localparam int STAT_SYNC = 6;
   localparam int STAT_DSR = 7;
   localparam int STAT_CTS = 8;
   localparam int STAT_W = 9;
   // ==========================================================
   // Reset values
   localparam logic [7:0] CMD_RESET = 8'h00;
   localparam logic [15:0] MODE_RESET = 16'h0000;
   // ==========================================================
   // Timing, in system clock cycles unless named _NS or _MHZ
   localparam int CLK_MHZ = 200;
   localparam int RDY_CLR_NS = 150;
   localparam int RDY_CLR_CYC = RDY_CLR_NS * CLK_MHZ / 1000;
   localparam int TRANSMIT_READY_MAX_CYC = 8;
   localparam int RECEIVE_READY_MAX_CYC = 24;
   localparam int ISYNC_MAX_CYC = 24;
   localparam int TXE_MAX_CYC = 20;
   // ==========================================================
   // State types
   typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_STOP} rx_state_t;
   typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_STOP, TX_END} tx_state_t;
endpackage

// ===== hdl/edge_sync.sv
// Two-flop synchroniser with edge detection for one outside signal.
// Assumes an asynchronous input; edges are found after the second flop.
`timescale 1ns/10ps
module edge_sync #(
   parameter logic INIT = 1'b0
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic async_i,
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);
   logic meta;
   logic stab;
   logic prev;

   // ==========================================================
   // Metastability guard; only stab reads meta
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         meta <= INIT;
         stab <= INIT;
         prev <= INIT;
      end else begin
         meta <= async_i;
         stab <= meta;
         prev <= stab;
      end
   end

   assign level_o = stab;
   assign rise_o = stab && !prev;
   assign fall_o = !stab && prev;
endmodule

// ===== hdl/serial_tx.sv
// Transmit shifter: start, eight data bits LSB first, stop in async mode;
// back-to-back characters with sync-character fill in sync mode.
// Assumes tick_i is a one-cycle pulse per transmit bit time.
`timescale 1ns/10ps
module serial_tx import usart_pkg::*; (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic tick_i,
   input wire logic go_i,
   input wire logic full_i,
   input wire logic [7:0] data_i,
   input wire logic sync_mode_i,
   input wire logic [7:0] sync_chr_i,
   output logic take_o,
   output logic done_o,
   output logic busy_o,
   output logic txd_o
);
   tx_state_t st, next_st;
   logic [2:0] cnt, next_cnt;
   logic [7:0] sh, next_sh;
   logic next_txd;
   logic fin;
   logic [7:0] load;

   // ==========================================================
   // Next state
   always_comb begin
      next_st = st;
      next_cnt = cnt;
      next_sh = sh;
      next_txd = txd_o;
      take_o = 1'b0;
      load = full_i ? data_i : sync_chr_i;
      fin = tick_i && ((st == TX_STOP && sync_mode_i) || st == TX_END);
      done_o = fin;
      if ((st == TX_IDLE && tick_i) || fin) begin
         // Loading at the closing tick keeps sync output gap-free
         next_st = TX_IDLE;
         next_txd = 1'b1;
         if (go_i && (full_i || sync_mode_i)) begin
            take_o = full_i;
            next_st = TX_DATA;
            if (sync_mode_i) begin
               next_txd = load[0];
               next_sh = {1'b0, load[7:1]};
               next_cnt = 3'h1;
            end else begin
               next_txd = 1'b0;
               next_sh = load;
               next_cnt = 3'h0;
            end
         end
      end else if (tick_i) begin
         unique case (st)
            TX_DATA: begin
               next_txd = sh[0];
               next_sh = {1'b0, sh[7:1]};
               next_cnt = cnt + 3'h1;
               if (cnt == 3'h7) begin
                  next_st = TX_STOP;
               end
            end
            TX_STOP: begin
               next_txd = 1'b1;
               next_st = TX_END;
            end
            default: begin
               next_st = TX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         st <= TX_IDLE;
         cnt <= 3'h0;
         sh <= 8'h00;
         txd_o <= 1'b1;
      end else begin
         st <= next_st;
         cnt <= next_cnt;
         sh <= next_sh;
         txd_o <= next_txd;
      end
   end

   assign busy_o = (st != TX_IDLE);
endmodule

// ===== testbench/line_model.sv
// Line side model: receive baud clock and serial data.
// Assumes 1X clocking driven by tasks from the bench.
`timescale 1ns/10ps
module line_model (
   output logic rx_clk_o,
   output logic rxd_o
);
   // =====
   // Frame sender
   initial begin
      rx_clk_o = 1'b0;
      rxd_o = 1'b1;
   end
   // Clock stands still between frames, line idles at mark
   // Bit time 48 ns: above the 1X limit, kept for run length
   task automatic send(input logic [9:0] frm, input int n);
      for (int i = 0; i < n; i++) begin
         rxd_o = frm[i];
         #24 rx_clk_o = 1'b1;
         #24 rx_clk_o = 1'b0;
      end
      rxd_o = 1'b1;
   endtask
endmodule

// ===== testbench/testbench.sv
// Self-checking bench of the serial transceiver core.
// Assumes usart_top and line_model; APB master tasks below.
`timescale 1ns/10ps
module testbench import usart_pkg::*; ();
   // =====
   // Signals
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic tbc = 1'b0, dsr_n = 1'b1, cts_n = 1'b1, ext = 1'b0;
   logic [7:0] paddr = 8'h00, d;
   logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'd75746;
   logic pready, pslverr, serr, rbc, rxd, txd, dtr_n, rts_n;
   logic trdy, rrdy, temp, sfnd;
   logic [8:0] sh;
   logic [7:0] pins;
   int n_fail = 0, checked = 0, k;
   logic [7:0] rq[$], tq[$];
   localparam int TXD = 0, DTR = 1, RTS = 2, TRDY = 3, RRDY = 4, TEMP = 5, SFND = 6;
   assign pins = {1'b0, sfnd, temp, rrdy, trdy, rts_n, dtr_n, txd};
   always #2.5 clk = ~clk;
   // Faster than the 1X limit, but still over three clocks per phase
   always #24 tbc = ~tbc;
   usart_top usart_top_inst (.CLK_I(clk), .RESET_I(rst), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .TRANSMIT_BAUD_CLOCK_I(tbc), .RECEIVE_BAUD_CLOCK_I(rbc),
      .SERIAL_IN_I(rxd), .DSR_N_I(dsr_n), .CTS_N_I(cts_n),
      .EXT_SYNC_I(ext), .SERIAL_OUT_O(txd), .DTR_N_O(dtr_n),
      .RTS_N_O(rts_n), .TRANSMIT_READY_O(trdy), .RECEIVE_READY_O(rrdy),
      .TRANSMITTER_EMPTY_O(temp), .SYNC_FOUND_O(sfnd));
   line_model line_model_inst (.rx_clk_o(rbc), .rxd_o(rxd));
   // =====
   // Tasks
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      pen <= 1'b1;
      // Only the watchdog ends a slave that never answers
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // Spacing covers the slower sync-mode recovery as well
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      tick(16);
      apb(1'b1, a, wd);
   endtask
   task automatic wchk(input int n, input int s, input logic e);
      #1;
      for (int i = 0; i < n && pins[s] !== e; i++) begin
         @(posedge clk);
         #1;
      end
      chk(pins[s], e);
   endtask
   task automatic rx_byte();
      d = rnd();
      rq.push_back(d);
      line_model_inst.send({1'b1, d, 1'b0}, 10);
   endtask
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // =====
   // Watchdog, far above the expected run length
   initial begin
      #100000;
      n_fail++;
      finish_test();
   end
   // =====
   // Main sequence
   initial begin
      tick(6);
      rst <= 1'b0;
      tick(1);
      #1;
      chk(temp, 1'b1);
      chk(rrdy, 1'b0);
      @(posedge clk);
      dsr_n <= 1'b0;
      cts_n <= 1'b0;
      wr(ADDR_CMD, 32'h23);
      wchk(8, DTR, 1'b0);
      wchk(8, RTS, 1'b0);
      wchk(8, TRDY, 1'b1);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk(rd[STAT_DSR], 1'b1);
      chk(rd[STAT_CTS], 1'b1);
      d = rnd();
      tq.push_back(d);
      wr(ADDR_DATA, {24'h0, d});
      wchk(30, TRDY, 1'b0);
      for (k = 0; k < 200 && txd !== 1'b0; k++) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
         @(negedge tbc);
         tick(6);
         sh = {txd, sh[8:1]};
      end
      chk(sh, {1'b1, tq.pop_front()});
      @(negedge tbc);
      wchk(20, TEMP, 1'b1);
      chk(trdy, 1'b1);
      // Break forces the line to space, release restores mark
      wr(ADDR_CMD, 32'h2B);
      wchk(8, TXD, 1'b0);
      wr(ADDR_CMD, 32'h23);
      wchk(8, TXD, 1'b1);
      // Receiver off: char still assembled, pin stays quiet
      rx_byte();
      tick(24);
      chk(rrdy, 1'b0);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk(rd[STAT_RECEIVE_READY], 1'b1);
      wr(ADDR_CMD, 32'h27);
      wchk(8, RRDY, 1'b1);
      apb(1'b0, ADDR_DATA, 32'h0);
      chk(rd, rq.pop_front());
      wchk(30, RRDY, 1'b0);
      rx_byte();
      wchk(19, RRDY, 1'b1);
      apb(1'b0, ADDR_DATA, 32'h0);
      chk(rd, rq.pop_front());
      rx_byte();
      wchk(19, RRDY, 1'b1);
      // Unread character overwritten: overrun, then error reset
      rx_byte();
      apb(1'b0, ADDR_STAT, 32'h0);
      chk(rd[STAT_OVR], 1'b1);
      wr(ADDR_CMD, 32'h37);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk(rd[STAT_OVR], 1'b0);
      @(posedge clk);
      rst <= 1'b1;
      tick(6);
      rst <= 1'b0;
      tick(1);
      #1;
      chk(rrdy, 1'b0);
      rq.delete();
      @(posedge clk);
      cts_n <= 1'b1;
      tick(20);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk(rd[STAT_CTS], 1'b0);
      chk(rd[STAT_RECEIVE_READY], 1'b0);
      // Internal pattern hunt
      wr(ADDR_MODE, 32'h0000_A501);
      wr(ADDR_CMD, 32'h84);
      line_model_inst.send({2'b11, 8'hA5}, 8);
      wchk(19, SFND, 1'b1);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk(rd[STAT_SYNC], 1'b1);
      wchk(8, SFND, 1'b0);
      // External detection ignores the pattern
      wr(ADDR_CMD, 32'h40);
      wr(ADDR_MODE, 32'h0000_A503);
      wr(ADDR_CMD, 32'h84);
      line_model_inst.send({2'b11, 8'hA5}, 8);
      tick(24);
      chk(sfnd, 1'b0);
      @(posedge clk);
      ext <= 1'b1;
      tick(4);
      line_model_inst.send(10'h3FF, 1);
      wchk(8, SFND, 1'b1);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk(rd[STAT_SYNC], 1'b1);
      tick(4);
      chk(sfnd, 1'b1);
      @(posedge clk);
      ext <= 1'b0;
      tick(6);
      apb(1'b0, ADDR_STAT, 32'h0);
      wchk(8, SFND, 1'b0);
      apb(1'b0, 8'h10, 32'h0);
      chk(serr, 1'b1);
      finish_test();
   end
endmodule
